// file: dmac_defs.svh
// Purpose: constants of the data-memory addressing and working-register core
// Assumes: 7-bit data-memory addresses, 8-bit data
// Notes: offsets, field positions, reset values and memory layout
// Functional notes
// - locations 00H and 02H redirect to memory addressed by pointer zero or one
// - port access whose pointer names a port reads 00H, writes nothing
// - direct port-to-port moves are not supported
// - both pointers are 7-bit ordinary registers feeding their port address
// - pointer zero reaches data memory only; pointer one also display memory
// - pointer zero always uses bank 0; pointer one uses the selected bank
// - direct operands always hit bank 0; other banks only via port one
// - bank select bit 0 picks bank 0 or 1; bits 1 to 7 read zero
// - every reset selects bank 0 except watchdog reset while sleeping
// - special registers decode the same whatever bank is selected
// - working register sits at 05H, is the ALU operand, takes immediates
// - memory-to-memory moves go through the working register, read then write
// - ALU does 8-bit add, subtract, decimal adjust, logic, rotate, inc, dec, skips
// - ALU operations update their arithmetic flags, except plain rotates, skips and move
// - flags register at 0AH, 8 bits, carry, nibble, zero, signed, sleep, expiry
// - software writes change arithmetic flags only, never sleep or expiry flags
// - sleep and expiry flags change only on watchdog, power-up, clear, sleep
// - arithmetic flags always show the latest operation affecting them
// - flag bits 0 to 3 carry, nibble, zero, signed; signed is carry mismatch
// - bit 4 sleep flag, bit 5 expiry flag, set and cleared by listed events
// - general memory is 20H to 7FH; unused locations below 20H read 00H
`ifndef DMAC_DEFS_SVH
`define DMAC_DEFS_SVH

`define ADDR_PORT0 7'h00
`define ADDR_PTR0 7'h01
`define ADDR_PORT1 7'h02
`define ADDR_PTR1 7'h03
`define ADDR_BANK 7'h04
`define ADDR_WORK 7'h05
`define ADDR_FLAGS 7'h0a

`define GEN_LO 7'h20
`define LCD_LO 7'h40
`define LCD_HI 7'h55
`define LCD_BASE 7'h60
`define MEM_DEPTH 118

`define FLG_C 0
`define FLG_NIB 1
`define FLG_Z 2
`define FLG_SGN 3
`define FLG_PD 4
`define FLG_EXP 5

`define RST_BYTE 8'h00
`define RST_PTR 7'h00
`define RST_BANK 1'b0
`define READ_LATENCY 2

`endif

// file: dmac_pkg.sv
// Purpose: types shared by the addressing core and its user
// Assumes: dmac_defs.svh for numeric constants
// Notes: request structs travel from the instruction logic
package dmac_pkg;

	// one data-memory access request
	typedef struct packed {
		logic valid;
		logic write;
		logic [6:0] addr;
		logic [7:0] wdata;
	} access_req_t;

	// alu operation codes
	typedef enum logic [4:0] {
		OP_ADD = 5'h00, OP_ADC = 5'h01, OP_SUB = 5'h02,
		OP_SUB_BORROW = 5'h03, OP_DECIMAL_ADJUST = 5'h04,
		OP_AND = 5'h05, OP_OR = 5'h06, OP_XOR = 5'h07,
		OP_CPL = 5'h08, OP_RL = 5'h09, OP_RR = 5'h0a, OP_RLC = 5'h0b,
		OP_RRC = 5'h0c, OP_INC = 5'h0d, OP_DEC = 5'h0e, OP_SZ = 5'h0f,
		OP_SNZ = 5'h10, OP_SIZ = 5'h11, OP_SDZ = 5'h12, OP_MOV = 5'h13
	} alu_op_t;

	// one alu request; operand is memory data or an immediate
	typedef struct packed {
		logic valid;
		alu_op_t op;
		logic [7:0] operand;
		logic to_mem;
		logic [6:0] addr;
	} alu_req_t;

	// watchdog, sleep and reset cause events
	typedef struct packed {
		logic power_up;
		logic wdt_sleep_rst;
		logic wdt_timeout;
		logic wdt_clear;
		logic sleep;
	} sys_evt_t;

	// resolved location class
	typedef enum logic [1:0] {
		LOC_SFR = 2'h0,
		LOC_MEM = 2'h1,
		LOC_VOID = 2'h2
	} loc_kind_t;

	typedef struct packed {
		loc_kind_t kind;
		logic [6:0] eff;
		logic [6:0] idx;
	} loc_t;

	// alu result and flag updates
	typedef struct packed {
		logic [7:0] y;
		logic c;
		logic nib;
		logic sgn;
		logic upd_c;
		logic upd_nib;
		logic upd_z;
		logic upd_sgn;
		logic wr;
		logic skip;
	} alu_out_t;

endpackage : dmac_pkg

// file: data_mem.sv
// Purpose: general and display data storage with registered read
// Assumes: one write and one read port, same clock
// Notes: contents are not reset
module data_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 118,
	parameter int AW = 7
) (
	input wire logic i_clk, // system clock
	input wire logic i_we, // write strobe
	input wire logic [AW-1:0] i_waddr, // write index
	input wire logic [WIDTH-1:0] i_wdata, // write data
	input wire logic i_re, // read strobe
	input wire logic [AW-1:0] i_raddr, // read index
	output logic [WIDTH-1:0] o_rdata // registered read data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// write port
	always_ff @(posedge i_clk)
	begin
		if (i_we)
		begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// registered read port
	always_ff @(posedge i_clk)
	begin
		if (i_re)
		begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule // data_mem

// file: dmac_core.sv
// Purpose: pointers, bank select, working register, alu and flags register
// Assumes: instruction logic issues at most one access or alu op a cycle
// Notes: reads answer two cycles after the request
`include "dmac_defs.svh"

module dmac_core (
	input wire logic i_clk, // system clock
	input wire logic i_rst_n, // synchronous reset, active low
	input dmac_pkg::access_req_t i_acc_req, // memory access request
	input dmac_pkg::alu_req_t i_alu_req, // alu operation request
	input dmac_pkg::sys_evt_t i_evt, // watchdog, sleep, reset cause
	output logic [7:0] o_rdata, // read answer
	output logic o_rvalid, // read answer strobe
	output logic [7:0] o_work, // working register
	output logic [7:0] o_flags, // flags register image
	output logic o_bank, // bank choice bit
	output logic [7:0] o_alu_y, // last alu result
	output logic o_alu_done, // alu op finished strobe
	output logic o_skip // skip decision of last alu op
);
	import dmac_pkg::*;

	typedef struct packed {
		logic [6:0] ptr0;
		logic [6:0] ptr1;
		logic bank;
		logic [7:0] work;
		logic fc;
		logic fac;
		logic fz;
		logic fov;
		logic fpd;
		logic fto;
		logic rd_pend;
		logic rd_mem;
		logic [7:0] rd_hold;
		logic [7:0] rdata;
		logic rvalid;
		logic [7:0] alu_y;
		logic alu_done;
		logic skip;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic [7:0] mem_q;
	logic mem_we;
	logic [6:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic mem_re;
	logic [6:0] mem_raddr;

	// map a data-memory address onto a storage class and index
	function automatic loc_t resolve(input logic [6:0] addr,
		input logic [6:0] p0, input logic [6:0] p1, input logic bk_sel);
		loc_t l;
		logic ind;
		logic bk;
		l.eff = addr;
		l.idx = 7'h00;
		l.kind = LOC_VOID;
		ind = 1'b0;
		bk = 1'b0; // direct operands use bank 0
		if (addr == `ADDR_PORT0)
		begin
			l.eff = p0; // pointer zero, bank 0 only
			ind = 1'b1;
		end
		else if (addr == `ADDR_PORT1)
		begin
			l.eff = p1; // pointer one, selected bank
			bk = bk_sel;
			ind = 1'b1;
		end
		if (ind && (l.eff == `ADDR_PORT0 || l.eff == `ADDR_PORT1))
		begin
			l.kind = LOC_VOID; // port through port reads zero
		end
		else if (l.eff < `GEN_LO)
		begin
			l.kind = LOC_SFR; // bank independent decode
		end
		else if (!bk)
		begin
			l.kind = LOC_MEM; // general memory
			l.idx = l.eff - `GEN_LO;
		end
		else if (l.eff >= `LCD_LO && l.eff <= `LCD_HI)
		begin
			l.kind = LOC_MEM; // display memory in bank 1
			l.idx = 7'(l.eff - `LCD_LO + `LCD_BASE);
		end
		return l;
	endfunction

	// special register read value
	function automatic logic [7:0] sfr_read(input logic [6:0] a,
		input state_t s);
		unique case (a)
			`ADDR_PTR0: return {1'b0, s.ptr0};
			`ADDR_PTR1: return {1'b0, s.ptr1};
			`ADDR_BANK: return {7'h00, s.bank}; // upper bits zero
			`ADDR_WORK: return s.work;
			`ADDR_FLAGS: return {2'b00, s.fto, s.fpd, s.fov, s.fz, s.fac,
				s.fc};
			default: return `RST_BYTE; // unused locations
		endcase
	endfunction

	// 8-bit add with carry, nibble carry and signed overflow
	function automatic alu_out_t add8(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		alu_out_t r;
		logic [8:0] s9;
		logic [4:0] s5;
		logic [7:0] s7;
		r = '0;
		s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		s5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
		r.y = s9[7:0];
		r.c = s9[8];
		r.nib = s5[4];
		r.sgn = s7[7] ^ s9[8]; // carry in vs carry out of top bit
		return r;
	endfunction

	// alu datapath; a is the working register, b the operand
	function automatic alu_out_t alu(input alu_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic c, input logic nib);
		alu_out_t r;
		logic [8:0] t;
		r = '0;
		t = 9'h000;
		unique case (op)
			OP_ADD: r = add8(a, b, 1'b0);
			OP_ADC: r = add8(a, b, c);
			OP_SUB: r = add8(a, ~b, 1'b1);
			OP_SUB_BORROW: r = add8(a, ~b, c); // carry set means no borrow
			OP_DECIMAL_ADJUST:
			begin
				t = {1'b0, a};
				if (a[3:0] > 4'h9 || nib)
				begin
					t = t + 9'h006;
				end
				if (t[8:4] > 5'h09 || c)
				begin
					t = t + 9'h060;
				end
				r.y = t[7:0];
				r.c = t[8] | c;
			end
			OP_AND: r.y = a & b;
			OP_OR: r.y = a | b;
			OP_XOR: r.y = a ^ b;
			OP_CPL: r.y = ~b;
			OP_RL: r.y = {b[6:0], b[7]};
			OP_RR: r.y = {b[0], b[7:1]};
			OP_RLC: {r.c, r.y} = {b, c};
			OP_RRC: {r.y, r.c} = {c, b};
			OP_INC, OP_SIZ: r.y = b + 8'h01;
			OP_DEC, OP_SDZ: r.y = b - 8'h01;
			default: r.y = b; // SZ and SNZ skip tests, move and unused codes
		endcase
		r.upd_c = op inside {OP_ADD, OP_ADC, OP_SUB, OP_SUB_BORROW,
			OP_DECIMAL_ADJUST, OP_RLC, OP_RRC};
		r.upd_nib = op inside {OP_ADD, OP_ADC, OP_SUB, OP_SUB_BORROW};
		r.upd_sgn = r.upd_nib;
		r.upd_z = op inside {OP_ADD, OP_ADC, OP_SUB, OP_SUB_BORROW, OP_AND,
			OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC};
		r.wr = !(op inside {OP_SZ, OP_SNZ});
		r.skip = (op == OP_SNZ) ? (b != 8'h00) : (r.y == 8'h00);
		if (!(op inside {OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ}))
		begin
			r.skip = 1'b0;
		end
		return r;
	endfunction

	// next-state logic: accesses, alu, flags and events
	always_comb
	begin
		alu_out_t ao;
		loc_t wl;
		loc_t rl;
		logic wr_en;
		logic [6:0] wr_addr;
		logic [7:0] wr_data;
		logic rd_en;
		ao = alu(i_alu_req.op, s_reg.work, i_alu_req.operand, s_reg.fc,
			s_reg.fac);
		s_next = s_reg;
		s_next.alu_done = 1'b0;
		s_next.rvalid = 1'b0;
		wr_en = 1'b0;
		wr_addr = i_acc_req.addr;
		wr_data = i_acc_req.wdata;
		rd_en = 1'b0;
		mem_we = 1'b0;
		mem_waddr = 7'h00;
		mem_wdata = wr_data;
		mem_re = 1'b0;
		mem_raddr = 7'h00;
		// alu op takes the cycle; a colliding access is dropped
		if (i_alu_req.valid)
		begin
			s_next.alu_y = ao.y;
			s_next.alu_done = 1'b1;
			s_next.skip = ao.skip;
			wr_addr = i_alu_req.addr;
			wr_data = ao.y;
			if (ao.wr && i_alu_req.to_mem)
			begin
				wr_en = 1'b1;
			end
			else if (ao.wr)
			begin
				s_next.work = ao.y; // result into working register
			end
		end
		else if (i_acc_req.valid)
		begin
			wr_en = i_acc_req.write; // moves: read, then write
			rd_en = !i_acc_req.write;
		end
		mem_wdata = wr_data;
		// write path
		wl = resolve(wr_addr, s_reg.ptr0, s_reg.ptr1, s_reg.bank);
		if (wr_en && wl.kind == LOC_MEM)
		begin
			mem_we = 1'b1;
			mem_waddr = wl.idx;
		end
		if (wr_en && wl.kind == LOC_SFR)
		begin
			unique case (wl.eff)
				`ADDR_PTR0: s_next.ptr0 = wr_data[6:0];
				`ADDR_PTR1: s_next.ptr1 = wr_data[6:0];
				`ADDR_BANK: s_next.bank = wr_data[0];
				`ADDR_WORK: s_next.work = wr_data;
				`ADDR_FLAGS:
				begin
					s_next.fc = wr_data[`FLG_C]; // sleep, expiry kept
					s_next.fac = wr_data[`FLG_NIB];
					s_next.fz = wr_data[`FLG_Z];
					s_next.fov = wr_data[`FLG_SGN];
				end
				default: s_next.rd_hold = s_reg.rd_hold; // owned elsewhere
			endcase
		end
		// alu flag updates come last so they reflect the latest op
		if (i_alu_req.valid)
		begin
			if (ao.upd_c)
			begin
				s_next.fc = ao.c;
			end
			if (ao.upd_nib)
			begin
				s_next.fac = ao.nib;
			end
			if (ao.upd_sgn)
			begin
				s_next.fov = ao.sgn;
			end
			if (ao.upd_z)
			begin
				s_next.fz = (ao.y == 8'h00);
			end
		end
		// read path, first stage
		rl = resolve(i_acc_req.addr, s_reg.ptr0, s_reg.ptr1, s_reg.bank);
		s_next.rd_pend = rd_en;
		s_next.rd_mem = rd_en && rl.kind == LOC_MEM;
		s_next.rd_hold = (rl.kind == LOC_SFR) ? sfr_read(rl.eff, s_reg) :
			`RST_BYTE; // void reads give zero
		if (rd_en && rl.kind == LOC_MEM)
		begin
			mem_re = 1'b1;
			mem_raddr = rl.idx;
		end
		// read path, answer stage
		if (s_reg.rd_pend)
		begin
			s_next.rdata = s_reg.rd_mem ? mem_q : s_reg.rd_hold;
			s_next.rvalid = 1'b1;
		end
		// sleep and expiry flags; a set wins over a clear
		if (i_evt.power_up || i_evt.wdt_clear)
		begin
			s_next.fpd = 1'b0;
			s_next.fto = 1'b0;
		end
		if (i_evt.sleep)
		begin
			s_next.fpd = 1'b1;
			s_next.fto = 1'b0;
		end
		if (i_evt.wdt_timeout)
		begin
			s_next.fto = 1'b1;
		end
		// reset keeps the bank only for a watchdog reset in sleep
		if (!i_rst_n)
		begin
			s_next.ptr0 = `RST_PTR;
			s_next.ptr1 = `RST_PTR;
			s_next.bank = i_evt.wdt_sleep_rst ? s_reg.bank : `RST_BANK;
			s_next.work = `RST_BYTE;
			{s_next.fc, s_next.fac, s_next.fz, s_next.fov} = 4'h0;
			s_next.rd_pend = 1'b0;
			s_next.rd_mem = 1'b0;
			s_next.rd_hold = `RST_BYTE;
			s_next.rdata = `RST_BYTE;
			s_next.rvalid = 1'b0;
			s_next.alu_y = `RST_BYTE;
			s_next.alu_done = 1'b0;
			s_next.skip = 1'b0;
			mem_we = 1'b0;
		end
	end

	// state register
	always_ff @(posedge i_clk)
	begin
		s_reg <= s_next;
	end

	data_mem #(
		.WIDTH(8),
		.DEPTH(`MEM_DEPTH),
		.AW(7)
	) u_mem (
		.i_clk(i_clk),
		.i_we(mem_we),
		.i_waddr(mem_waddr),
		.i_wdata(mem_wdata),
		.i_re(mem_re),
		.i_raddr(mem_raddr),
		.o_rdata(mem_q)
	);

	// outputs straight from the state flops
	assign o_rdata = s_reg.rdata;
	assign o_rvalid = s_reg.rvalid;
	assign o_work = s_reg.work;
	assign o_flags = {2'b00, s_reg.fto, s_reg.fpd, s_reg.fov, s_reg.fz,
		s_reg.fac, s_reg.fc};
	assign o_bank = s_reg.bank;
	assign o_alu_y = s_reg.alu_y;
	assign o_alu_done = s_reg.alu_done;
	assign o_skip = s_reg.skip;

	// checks
	a_port_void_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_acc_req.valid && !i_acc_req.write && !i_alu_req.valid &&
		((i_acc_req.addr == `ADDR_PORT0 && s_reg.ptr0 == `ADDR_PORT1) ||
		(i_acc_req.addr == `ADDR_PORT1 && s_reg.ptr1 == `ADDR_PORT1)))
		|-> ##2 (o_rvalid && o_rdata == 8'h00))
		else $error("port read through a port is not zero");
	a_port_redirect: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_acc_req.valid && i_acc_req.write && !i_alu_req.valid &&
		i_acc_req.addr == `ADDR_PORT0 && s_reg.ptr0 == `ADDR_WORK)
		|=> o_work == $past(i_acc_req.wdata))
		else $error("port write not redirected by pointer");
	a_bank_read_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_acc_req.valid && !i_acc_req.write && !i_alu_req.valid &&
		i_acc_req.addr == `ADDR_BANK) |-> ##2 (o_rdata[7:1] == 7'h00 &&
		o_rdata[0] == $past(o_bank, 2)))
		else $error("bank select read wrong");
	a_bank_reset_keep: assert property (@(posedge i_clk)
		(!i_rst_n && i_evt.wdt_sleep_rst) |=> o_bank == $past(o_bank))
		else $error("bank changed by watchdog sleep reset");
	a_bank_reset_clr: assert property (@(posedge i_clk)
		(!i_rst_n && !i_evt.wdt_sleep_rst) |=> !o_bank)
		else $error("bank not cleared by reset");
	a_flags_protect: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_acc_req.valid && i_acc_req.write && !i_alu_req.valid &&
		i_acc_req.addr == `ADDR_FLAGS && i_evt == '0)
		|=> (o_flags[5:4] == $past(o_flags[5:4]) &&
		o_flags[3:0] == $past(i_acc_req.wdata[3:0])))
		else $error("flags write touched protected bits");
	a_sleep_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_evt.sleep && !i_evt.wdt_timeout) |=> (o_flags[4] && !o_flags[5]))
		else $error("sleep did not set sleep flag");
	a_add_result: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_alu_req.valid && i_alu_req.op == OP_ADD && !i_alu_req.to_mem)
		|=> ({o_flags[0], o_work} == {1'b0, $past(o_work)} +
		{1'b0, $past(i_alu_req.operand)} && o_flags[2] == (o_work == 8'h00)))
		else $error("add result or flags wrong");
	a_sfr_any_bank: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(o_bank && i_acc_req.valid && !i_acc_req.write && !i_alu_req.valid &&
		i_acc_req.addr == `ADDR_WORK) |-> ##2 (o_rdata == $past(o_work, 2)))
		else $error("special register read depends on bank");

endmodule // dmac_core

// file: core_seq_model.sv
// Purpose: instruction-side model that drives the addressing core
// Assumes: one request per call, three for move, each held for a single sampling edge
// Notes: memory moves go read, working register, then write
module core_seq_model (
	input wire logic i_clk, // system clock
	input wire logic [7:0] i_rdata, // read answer
	input wire logic i_rvalid, // read answer strobe
	input wire logic [7:0] i_work, // working register
	output dmac_pkg::access_req_t o_acc_req, // access request
	output dmac_pkg::alu_req_t o_alu_req, // alu request
	output dmac_pkg::sys_evt_t o_evt // system events
);
	timeunit 1ns;
	timeprecision 1ps;
	import dmac_pkg::*;

	// idle requests, power-up qualifier raised
	initial
	begin
		o_acc_req = '0;
		o_alu_req = '0;
		o_evt = 5'h10;
	end

	// one access, request stands for one edge
	task automatic acc(input logic w, input logic [6:0] a,
		input logic [7:0] d);
		@(posedge i_clk);
		o_acc_req <= {1'b1, w, a, d};
		@(posedge i_clk);
		o_acc_req <= '0;
	endtask

	// read; answer stands in the cycle after the second edge past the request
	task automatic rd(input logic [6:0] a, output logic [7:0] d,
		output logic v);
		acc(1'b0, a, 8'h00);
		@(posedge i_clk);
		#1;
		d = i_rdata;
		v = i_rvalid;
	endtask

	// alu request; results settle just after the taking edge
	task automatic alu(input alu_op_t op, input logic [7:0] b,
		input logic tm, input logic [6:0] a);
		@(posedge i_clk);
		o_alu_req <= {1'b1, op, b, tm, a};
		@(posedge i_clk);
		o_alu_req <= '0;
		#1;
	endtask

	// event levels change at an edge
	task automatic set_evt(input sys_evt_t e);
		@(posedge i_clk);
		o_evt <= e;
	endtask

	// memory to memory through the working register
	task automatic move(input logic [6:0] s, input logic [6:0] t);
		logic [7:0] d;
		logic v;
		rd(s, d, v); // fetch source
		alu(OP_MOV, d, 1'b0, 7'h00); // into working reg
		acc(1'b1, t, i_work); // store target
	endtask
endmodule // core_seq_model

// file: dmac_core_tb_top.sv
// Purpose: self-checking bench of the addressing core
// Assumes: partner model issues every request
// Notes: expected values are worked out by hand below
`include "dmac_defs.svh"

module dmac_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dmac_pkg::*;

	typedef struct packed {
		alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic [3:0] f0;
		logic [7:0] y;
		logic [3:0] f1;
		logic sk;
	} row_t;

	logic i_clk;
	logic i_rst_n = 1'b0;
	access_req_t acc;
	alu_req_t alu;
	sys_evt_t evt;
	logic [7:0] rdata, work, flags, alu_y;
	logic rvalid, bank, done, skip;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	// op, work, operand, flags in, result, flags out, skip
	row_t rows [0:20] = '{
		'{OP_ADD, 8'h7f, 8'h01, 4'h0, 8'h80, 4'ha, 1'b0},
		'{OP_ADC, 8'hff, 8'h00, 4'h1, 8'h00, 4'h7, 1'b0},
		'{OP_SUB, 8'h10, 8'h20, 4'h0, 8'hf0, 4'h2, 1'b0},
		'{OP_SUB_BORROW, 8'h80, 8'h01, 4'h0, 8'h7e, 4'h9, 1'b0},
		'{OP_DECIMAL_ADJUST, 8'h15, 8'h00, 4'h2, 8'h1b, 4'h2, 1'b0},
		'{OP_DECIMAL_ADJUST, 8'h9a, 8'h00, 4'h0, 8'h00, 4'h1, 1'b0},
		'{OP_AND, 8'hf0, 8'h0f, 4'hb, 8'h00, 4'hf, 1'b0},
		'{OP_OR, 8'h50, 8'h0a, 4'h4, 8'h5a, 4'h0, 1'b0},
		'{OP_XOR, 8'h5a, 8'h5a, 4'h0, 8'h00, 4'h4, 1'b0},
		'{OP_CPL, 8'h00, 8'hff, 4'h0, 8'h00, 4'h4, 1'b0},
		'{OP_RL, 8'h00, 8'h81, 4'h1, 8'h03, 4'h1, 1'b0},
		'{OP_RR, 8'h00, 8'h01, 4'h0, 8'h80, 4'h0, 1'b0},
		'{OP_RLC, 8'h00, 8'h80, 4'h0, 8'h00, 4'h1, 1'b0},
		'{OP_RRC, 8'h00, 8'h02, 4'h1, 8'h81, 4'h0, 1'b0},
		'{OP_INC, 8'h00, 8'hff, 4'h0, 8'h00, 4'h4, 1'b0},
		'{OP_DEC, 8'h00, 8'h01, 4'h1, 8'h00, 4'h5, 1'b0},
		'{OP_SZ, 8'h00, 8'h00, 4'h0, 8'h00, 4'h0, 1'b1},
		'{OP_SNZ, 8'h00, 8'h00, 4'h0, 8'h00, 4'h0, 1'b0},
		'{OP_SIZ, 8'h00, 8'hff, 4'h0, 8'h00, 4'h0, 1'b1},
		'{OP_SDZ, 8'h00, 8'h02, 4'h0, 8'h01, 4'h0, 1'b0},
		'{OP_MOV, 8'h00, 8'h3c, 4'h5, 8'h3c, 4'h5, 1'b0}};

	dmac_core uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_acc_req(acc),
		.i_alu_req(alu), .i_evt(evt), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_work(work), .o_flags(flags), .o_bank(bank), .o_alu_y(alu_y),
		.o_alu_done(done), .o_skip(skip));

	core_seq_model sm (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
		.i_work(work), .o_acc_req(acc), .o_alu_req(alu), .o_evt(evt));

	// free-running system clock
	initial
	begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// hang guard
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fails++;
			final_report();
		end
	end

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("Error %0t: byte %h want %h", $time, g, e);
		end
	endtask

	task automatic chk1(input logic g, input logic e);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("Error %0t: bit %b want %b", $time, g, e);
		end
	endtask

	// write, then let the target settle before any look
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		sm.acc(1'b1, a, d);
		#1;
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		sm.rd(a, d, v);
		chk1(v, 1'b1);
		chk8(d, e);
	endtask

	// one-cycle event, settled afterwards
	task automatic pulse(input sys_evt_t e);
		sm.set_evt(e);
		sm.set_evt('0);
		#1;
	endtask

	// seven edges low with the given reset cause
	task automatic do_reset(input sys_evt_t e);
		sm.set_evt(e);
		i_rst_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		sm.set_evt('0);
		i_rst_n <= 1'b1;
		#1;
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		do_reset(5'h10);
		chk8(flags, 8'h00); // cleared flags
		chk1(bank, 1'b0); // bank 0
		foreach (rows[i])
		begin
			sm.alu(OP_MOV, rows[i].a, 1'b0, 7'h00);
			wr(`ADDR_FLAGS, {4'h0, rows[i].f0});
			sm.alu(rows[i].op, rows[i].b, 1'b0, 7'h00);
			chk1(done, 1'b1); // op finished
			chk8(work, rows[i].y); // result
			chk8(alu_y, rows[i].y); // alu result output
			chk8(flags, {4'h0, rows[i].f1}); // flags
			chk1(skip, rows[i].sk); // skip decision
		end
		$display("test alu done");
		wr(`ADDR_PTR0, 8'ha5);
		rdchk(`ADDR_PTR0, 8'h25); // seven bits
		wr(`ADDR_PORT0, 8'h3c);
		rdchk(7'h25, 8'h3c); // redirected write
		rdchk(`ADDR_PORT0, 8'h3c); // redirected read
		wr(`ADDR_PTR1, 8'h02);
		rdchk(`ADDR_PORT1, 8'h00); // port via port
		wr(`ADDR_PORT1, 8'h55);
		rdchk(`ADDR_PTR1, 8'h02); // nothing written
		sm.move(7'h25, 7'h26);
		rdchk(7'h26, 8'h3c); // moved copy
		wr(7'h1b, 8'hff);
		rdchk(7'h1b, 8'h00); // unused reads zero
		wr(7'h7f, 8'h81);
		rdchk(7'h7f, 8'h81); // top of memory
		wr(`ADDR_PTR0, 8'h05);
		wr(`ADDR_PORT0, 8'h6b);
		chk8(work, 8'h6b); // port write reaches special reg
		wr(`ADDR_WORK, 8'h9c);
		chk8(work, 8'h9c); // mapped working reg
		sm.alu(OP_ADD, 8'h01, 1'b1, 7'h30);
		rdchk(7'h30, 8'h9d); // immediate sum stored
		$display("test memory done");
		wr(7'h40, 8'h11);
		wr(`ADDR_BANK, 8'hff);
		rdchk(`ADDR_BANK, 8'h01); // upper bits zero
		chk1(bank, 1'b1); // bank 1 chosen
		wr(`ADDR_PTR1, 8'h40);
		wr(`ADDR_PORT1, 8'h77);
		rdchk(`ADDR_PORT1, 8'h77); // display area
		rdchk(7'h40, 8'h11); // direct hits bank 0
		wr(`ADDR_PTR0, 8'h40);
		rdchk(`ADDR_PORT0, 8'h11); // pointer zero in bank 0
		rdchk(`ADDR_WORK, 8'h9c); // special regs unbanked
		rdchk(`ADDR_PTR1, 8'h40); // special regs unbanked
		wr(`ADDR_PTR1, 8'h25);
		rdchk(`ADDR_PORT1, 8'h00); // hole in bank 1
		wr(`ADDR_BANK, 8'h00);
		rdchk(`ADDR_PORT1, 8'h3c); // follows bank choice
		$display("test bank done");
		wr(`ADDR_FLAGS, 8'hff);
		chk8(flags, 8'h0f); // arithmetic bits only
		pulse(5'h01);
		chk8(flags, 8'h1f); // sleep sets flag
		pulse(5'h04);
		chk8(flags, 8'h3f); // expiry set
		wr(`ADDR_FLAGS, 8'h00);
		chk8(flags, 8'h30); // protected bits kept
		pulse(5'h01);
		chk8(flags, 8'h10); // sleep clears expiry
		pulse(5'h02);
		chk8(flags, 8'h00); // watchdog clear
		$display("test flags done");
		wr(`ADDR_BANK, 8'h01);
		pulse(5'h01);
		do_reset(5'h08);
		chk1(bank, 1'b1); // sleeping watchdog reset
		do_reset(5'h00);
		chk1(bank, 1'b0); // plain reset
		chk8(flags, 8'h10); // sleep flag survives
		chk8(work, 8'h00); // working reg cleared
		$display("test reset done");
		final_report();
	end
endmodule // dmac_core_tb_top
